// file: vfd_pkg.sv
package vfd_pkg;

   // display geometry
   localparam int          DIGITS         = 16;
   localparam int          SEGS           = 16;
   localparam int          SYMS           = 2;
   localparam int          PAT_RAM_ENTRIES = 16;
   localparam int          ROM_ENTRIES    = 240;

   // command opcodes, upper nibble of the first byte
   localparam logic [3:0]  OP_CHAR        = 4'h1;
   localparam logic [3:0]  OP_PAT         = 4'h2;
   localparam logic [3:0]  OP_SYM         = 4'h3;
   localparam logic [3:0]  OP_DUTY        = 4'h5;
   localparam logic [3:0]  OP_DIGITS      = 4'h6;
   localparam logic [3:0]  OP_LIGHTS      = 4'h7;

   // all-lights field positions
   localparam int          LIGHT_OFF_BIT  = 0;
   localparam int          LIGHT_ON_BIT   = 1;

   // codes below this value select the writable pattern ram
   localparam logic [7:0]  PAT_RAM_LIMIT  = 8'h10;

   // reset values
   localparam logic [3:0]  DUTY_RST       = 4'h0;
   localparam logic [3:0]  DIGITS_RST     = 4'h0;
   localparam logic [1:0]  LIGHTS_RST     = 2'h0;
   localparam logic [3:0]  ADDR_RST       = 4'h0;

   // timing: clock rate and one sixteenth of a digit slot
   localparam int          SYS_CLK_MHZ    = 40;
   localparam int          SUBSTEP_NS     = 1000;
   localparam int          SUBSTEP_CYC    = (SUBSTEP_NS * SYS_CLK_MHZ + 999) / 1000;
   // least host gap between pattern bytes of one write sequence
   localparam int          BYTE_GAP_NS    = 250;
   localparam int          BYTE_GAP_CYC   = (BYTE_GAP_NS * SYS_CLK_MHZ + 999) / 1000;

   // buffering
   localparam int          FIFO_DEPTH     = 4;

   // one received byte and whether it opened a frame
   typedef struct packed {
      logic       frame_start;
      logic [7:0] data;
   } vfd_word_s;

   // drive of the tube in one cycle
   typedef struct packed {
      logic [DIGITS-1:0] grid;
      logic [SEGS-1:0]   seg;
      logic [SYMS-1:0]   sym;
   } vfd_drive_s;

   // interpreter states
   typedef enum logic [2:0] {
      ST_CMD,
      ST_CHAR,
      ST_PAT_LO,
      ST_PAT_HI,
      ST_SYM,
      ST_SKIP
   } vfd_state_e;

endpackage : vfd_pkg

// file: vfd_fifo.sv
module vfd_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk,   // system clock
   input  wire logic             rst_n,     // async reset, active low
   input  wire logic [WIDTH-1:0] in_data,   // write word
   input  wire logic             in_valid,  // write request
   output logic                  in_ready,  // room for a word
   output logic      [WIDTH-1:0] out_data,  // head word
   output logic                  out_valid, // head word present
   input  wire logic             out_ready  // reader takes head
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [CW-1:0]    count_r;
   logic             push;
   logic             pop;

   // handshakes and head word
   assign in_ready  = (count_r != CW'(DEPTH));
   assign out_valid = (count_r != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_r[rd_ptr_r];

   // storage
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule : vfd_fifo

// file: vfd_ctrl.sv
module vfd_ctrl (
   input  wire logic   sys_clk,               // 40 MHz system clock
   input  wire logic   rst_n,                 // hardware reset, active low
   input  wire logic   select_n_pin,          // link select, low enables transfer
   input  wire logic   shift_clock_pin,       // link shift clock
   input  wire logic   serial_data_pin,       // link serial data
   output logic [15:0] grid_outputs,          // grid drive, one per digit
   output logic [15:0] anode_segment_outputs, // segment drive
   output logic [1:0]  symbol_outputs,        // symbol drive
   output logic [3:0]  duty_bits,             // current duty setting
   output logic [3:0]  digit_count_bits       // current digit count setting
);
   import vfd_pkg::*;

   localparam int WW = $bits(vfd_word_s);

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic       sel_meta_r;
   logic       sel_sync_r;
   logic       sel_d_r;
   logic       sck_meta_r;
   logic       sck_sync_r;
   logic       sck_d_r;
   logic       dat_meta_r;
   logic       dat_sync_r;

   // two flops per pin, the first read only by the second
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_meta_r <= 1'b1;
         sel_sync_r <= 1'b1;
         sck_meta_r <= 1'b0;
         sck_sync_r <= 1'b0;
         dat_meta_r <= 1'b0;
         dat_sync_r <= 1'b0;
      end else begin
         sel_meta_r <= select_n_pin;
         sel_sync_r <= sel_meta_r;
         sck_meta_r <= shift_clock_pin;
         sck_sync_r <= sck_meta_r;
         dat_meta_r <= serial_data_pin;
         dat_sync_r <= dat_meta_r;
      end
   end

   // delayed copies for edge finding
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_d_r <= 1'b1;
         sck_d_r <= 1'b0;
      end else begin
         sel_d_r <= sel_sync_r;
         sck_d_r <= sck_sync_r;
      end
   end

   logic sck_rise;
   logic sel_fall;

   assign sck_rise = sck_sync_r && !sck_d_r && !sel_sync_r;
   assign sel_fall = !sel_sync_r && sel_d_r;

   // ---------------------------------------------------------------
   // serial shifter
   // ---------------------------------------------------------------
   logic [7:0] shift_r;
   logic [2:0] bit_cnt_r;
   logic       first_r;
   vfd_word_s  pend_r;
   logic       pend_vld_r;
   logic       fifo_in_ready;

   // LSB first shift, bit count restarts when select is high
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r   <= 8'h00;
         bit_cnt_r <= 3'h0;
      end else if (sel_sync_r) begin
         bit_cnt_r <= 3'h0;
      end else if (sck_rise) begin
         shift_r   <= {dat_sync_r, shift_r[7:1]};
         bit_cnt_r <= bit_cnt_r + 3'h1;
      end
   end

   logic byte_done;
   assign byte_done = sck_rise && (bit_cnt_r == 3'h7);

   // marks the first byte after select falls
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         first_r <= 1'b0;
      end else if (sel_fall) begin
         first_r <= 1'b1;
      end else if (byte_done) begin
         first_r <= 1'b0;
      end
   end

   // internal load: byte held until the fifo has room
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r     <= '0;
         pend_vld_r <= 1'b0;
      end else if (byte_done) begin
         pend_r.data        <= {dat_sync_r, shift_r[7:1]};
         pend_r.frame_start <= first_r;
         pend_vld_r         <= 1'b1;
      end else if (fifo_in_ready) begin
         pend_vld_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // byte buffer
   // ---------------------------------------------------------------
   logic [WW-1:0] fifo_out;
   logic          fifo_out_valid;
   logic          take;
   vfd_word_s     exec_r;
   logic          exec_vld_r;

   vfd_fifo #(
      .WIDTH (WW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_data   (pend_r),
      .in_valid  (pend_vld_r),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_out_valid),
      .out_ready (take)
   );

   // interpreter takes a byte, then spends one cycle executing it
   assign take = fifo_out_valid && !exec_vld_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         exec_r     <= '0;
         exec_vld_r <= 1'b0;
      end else begin
         exec_vld_r <= take;
         if (take) begin
            exec_r <= vfd_word_s'(fifo_out);
         end
      end
   end

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   vfd_state_e state_r;
   logic       is_cmd;
   logic [3:0] op;
   logic [3:0] arg;
   logic       wr_char;
   logic       wr_pat;
   logic       wr_sym;

   assign is_cmd  = exec_vld_r && (exec_r.frame_start || state_r == ST_CMD);
   assign op      = exec_r.data[7:4];
   assign arg     = exec_r.data[3:0];
   assign wr_char = exec_vld_r && !is_cmd && (state_r == ST_CHAR);
   assign wr_pat  = exec_vld_r && !is_cmd && (state_r == ST_PAT_HI);
   assign wr_sym  = exec_vld_r && !is_cmd && (state_r == ST_SYM);

   // sequence state: first byte of a frame is a command, rest is data
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_CMD;
      end else if (is_cmd) begin
         unique case (op)
            OP_CHAR: state_r <= ST_CHAR;
            OP_PAT:  state_r <= ST_PAT_LO;
            OP_SYM:  state_r <= ST_SYM;
            default: state_r <= ST_SKIP;
         endcase
      end else if (exec_vld_r) begin
         unique case (state_r)
            // pattern bytes pair into one item
            ST_PAT_LO: state_r <= ST_PAT_HI;
            ST_PAT_HI: state_r <= ST_PAT_LO;
            default:   state_r <= state_r;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // storage: character codes, patterns, symbols
   // ---------------------------------------------------------------
   logic [3:0]  char_addr_r;
   logic [3:0]  pat_addr_r;
   logic [3:0]  sym_addr_r;
   logic [7:0]  pat_lo_r;
   logic [7:0]  char_ram_r [DIGITS];
   logic [15:0] pat_ram_r  [PAT_RAM_ENTRIES];
   logic [1:0]  sym_ram_r  [DIGITS];

   // digit address from low nibble, auto increment
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         char_addr_r <= ADDR_RST;
      end else if (is_cmd && op == OP_CHAR) begin
         char_addr_r <= arg;
      end else if (wr_char) begin
         char_addr_r <= char_addr_r + 4'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pat_addr_r <= ADDR_RST;
      end else if (is_cmd && op == OP_PAT) begin
         pat_addr_r <= arg;
      end else if (wr_pat) begin
         pat_addr_r <= pat_addr_r + 4'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sym_addr_r <= ADDR_RST;
      end else if (is_cmd && op == OP_SYM) begin
         sym_addr_r <= arg;
      end else if (wr_sym) begin
         sym_addr_r <= sym_addr_r + 4'h1;
      end
   end

   // low pattern byte waits for its partner
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pat_lo_r <= 8'h00;
      end else if (exec_vld_r && !is_cmd && state_r == ST_PAT_LO) begin
         pat_lo_r <= exec_r.data;
      end
   end

   // one entry per digit or pattern slot
   generate
      for (genvar g = 0; g < DIGITS; g++) begin : g_ram
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               char_ram_r[g] <= 8'h00;
               pat_ram_r[g]  <= 16'h0000;
               sym_ram_r[g]  <= 2'h0;
            end else begin
               if (wr_char && char_addr_r == 4'(g)) begin
                  char_ram_r[g] <= exec_r.data;
               end
               // bit 0 first, low byte then high byte
               if (wr_pat && pat_addr_r == 4'(g)) begin
                  pat_ram_r[g] <= {exec_r.data, pat_lo_r};
               end
               if (wr_sym && sym_addr_r == 4'(g)) begin
                  sym_ram_r[g] <= exec_r.data[1:0];
               end
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // control settings
   // ---------------------------------------------------------------
   logic [3:0] duty_r;
   logic [3:0] count_r;
   logic [1:0] lights_r;

   // cleared at reset, set by one-byte commands
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         duty_r   <= DUTY_RST;
         count_r  <= DIGITS_RST;
         lights_r <= LIGHTS_RST;
      end else if (is_cmd) begin
         if (op == OP_DUTY) begin
            duty_r <= arg;
         end
         if (op == OP_DIGITS) begin
            count_r <= arg;
         end
         if (op == OP_LIGHTS) begin
            lights_r <= arg[1:0];
         end
      end
   end

   assign duty_bits        = duty_r;
   assign digit_count_bits = count_r;

   // ---------------------------------------------------------------
   // scanning
   // ---------------------------------------------------------------
   localparam int TW = $clog2(SUBSTEP_CYC);

   logic [TW-1:0] tick_cnt_r;
   logic          tick;
   logic [3:0]    sub_r;
   logic [3:0]    digit_r;
   logic [3:0]    last_digit;

   // one-cycle enable every sixteenth of a digit slot
   assign tick = (tick_cnt_r == TW'(SUBSTEP_CYC - 1));

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
      end
   end

   assign last_digit = (count_r == 4'h0) ? 4'hf : count_r - 4'h1;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sub_r   <= 4'h0;
         digit_r <= 4'h0;
      end else if (tick) begin
         sub_r <= sub_r + 4'h1;
         if (sub_r == 4'hf) begin
            digit_r <= (digit_r >= last_digit) ? 4'h0 : digit_r + 4'h1;
         end
      end
   end

   // fixed rom; glyph data comes with the mask set, this is a stand-in
   function automatic logic [15:0] rom_glyph(input logic [7:0] code);
      rom_glyph = {code ^ 8'h5a, ~code};
   endfunction : rom_glyph

   logic [7:0]  cur_code;
   logic [15:0] cur_pat;
   vfd_drive_s  drive_nxt;
   vfd_drive_s  drive_r;

   // low codes use pattern ram, the rest use the rom
   assign cur_code = char_ram_r[digit_r];
   assign cur_pat  = (cur_code < PAT_RAM_LIMIT) ? pat_ram_r[cur_code[3:0]]
                                                : rom_glyph(cur_code);

   // next drive of the tube
   always_comb begin
      drive_nxt = '0;
      // grid lit for duty sixteenths, digit n on grid n
      if (sub_r < duty_r) begin
         drive_nxt.grid[digit_r] = 1'b1;
      end
      // segments and symbols of the scanned digit
      drive_nxt.seg = cur_pat;
      drive_nxt.sym = sym_ram_r[digit_r];
      if (lights_r[LIGHT_ON_BIT]) begin
         drive_nxt.seg = '1;
         drive_nxt.sym = '1;
      end else if (lights_r[LIGHT_OFF_BIT]) begin
         drive_nxt.seg = '0;
         drive_nxt.sym = '0;
      end
   end

   // registered tube drive, all low at reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_r <= '0;
      end else begin
         drive_r <= drive_nxt;
      end
   end

   assign grid_outputs          = drive_r.grid;
   assign anode_segment_outputs = drive_r.seg;
   assign symbol_outputs        = drive_r.sym;

endmodule : vfd_ctrl

// file: vfd_ctrl_assertions.sv
module vfd_ctrl_assertions
   import vfd_pkg::*;
(
   input wire logic        sys_clk,               // system clock
   input wire logic        rst_n,                 // async reset
   input wire logic        select_n_pin,          // link select
   input wire logic [15:0] grid_outputs,          // grid drive
   input wire logic [15:0] anode_segment_outputs, // segment drive
   input wire logic [1:0]  symbol_outputs,        // symbol drive
   input wire logic [3:0]  duty_bits,             // duty setting
   input wire logic [3:0]  digit_count_bits       // digit count
);
   logic [5:0]  quiet_r;
   logic [9:0]  duty_age_r;
   logic [9:0]  cnt_age_r;
   logic [9:0]  run_r;
   logic [15:0] grid_q_r;
   logic [15:0] last_r;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // cycles since the link was last selected
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) quiet_r <= 6'h0;
      else if (!select_n_pin) quiet_r <= 6'h0;
      else if (quiet_r != 6'h3f) quiet_r <= quiet_r + 6'h1;
   end
   // cycles since each setting last changed
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) duty_age_r <= 10'h0;
      else if ($changed(duty_bits)) duty_age_r <= 10'h0;
      else if (duty_age_r != 10'h3ff) duty_age_r <= duty_age_r + 10'h1;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) cnt_age_r <= 10'h0;
      else if ($changed(digit_count_bits)) cnt_age_r <= 10'h0;
      else if (cnt_age_r != 10'h3ff) cnt_age_r <= cnt_age_r + 10'h1;
   end
   // length of each grid pulse and the last digit lit
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_r <= 10'h0;
         grid_q_r <= 16'h0;
         last_r <= 16'h0;
      end else begin
         run_r <= (grid_outputs == 16'h0) ? 10'h0 :
                  (grid_outputs == grid_q_r) ? run_r + 10'h1 : 10'h1;
         grid_q_r <= grid_outputs;
         if (grid_outputs != 16'h0) last_r <= grid_outputs;
      end
   end

   sequence s_out_of_reset;
      $rose(rst_n);
   endsequence
   sequence s_digit_on;
      grid_outputs == 16'h0 ##1 grid_outputs != 16'h0;
   endsequence

   property p_reset_vals;
      s_out_of_reset |-> duty_bits == DUTY_RST && digit_count_bits == DIGITS_RST
                         && grid_outputs == 16'h0;
   endproperty
   property p_grid_onehot;
      $onehot0(grid_outputs);
   endproperty
   property p_count_limit;
      (cnt_age_r == 10'h3ff && digit_count_bits != 4'h0)
         |-> (grid_outputs >> digit_count_bits) == 16'h0;
   endproperty
   property p_duty_dark;
      (duty_age_r > 10'h3 && duty_bits == 4'h0) |-> grid_outputs == 16'h0;
   endproperty
   property p_on_time;
      (grid_q_r != 16'h0 && grid_outputs != grid_q_r && duty_age_r == 10'h3ff
       && cnt_age_r == 10'h3ff) |-> run_r == 10'(duty_bits) * 10'(SUBSTEP_CYC);
   endproperty
   property p_digit_order;
      s_digit_on |-> cnt_age_r != 10'h3ff || duty_age_r != 10'h3ff
         || grid_outputs == 16'h1 || grid_outputs == {last_r[14:0], 1'b0};
   endproperty
   property p_quiet_settings;
      ($changed(duty_bits) || $changed(digit_count_bits)) |-> quiet_r < 6'h14;
   endproperty
   property p_seg_hold;
      (quiet_r == 6'h3f && grid_outputs != 16'h0 && $stable(grid_outputs)
       && grid_outputs == $past(grid_outputs, 2))
         |-> $stable(anode_segment_outputs) && $stable(symbol_outputs);
   endproperty

   a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
   a_grid_onehot: assert property (p_grid_onehot) else $error("two grids on");
   a_count_limit: assert property (p_count_limit) else $error("grid past count");
   a_duty_dark: assert property (p_duty_dark) else $error("grid lit at duty 0");
   a_on_time: assert property (p_on_time) else $error("grid pulse length");
   a_digit_order: assert property (p_digit_order) else $error("scan order");
   a_quiet_settings: assert property (p_quiet_settings) else $error("setting moved");
   a_seg_hold: assert property (p_seg_hold) else $error("segments moved in slot");
endmodule : vfd_ctrl_assertions

bind vfd_ctrl vfd_ctrl_assertions u_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .select_n_pin(select_n_pin),
   .grid_outputs(grid_outputs), .anode_segment_outputs(anode_segment_outputs),
   .symbol_outputs(symbol_outputs), .duty_bits(duty_bits),
   .digit_count_bits(digit_count_bits)
);

// file: vfd_host_model.sv
module vfd_host_model (
   input wire logic sys_clk,         // pacing clock
   output logic     select_n_pin,    // link select, low in a frame
   output logic     shift_clock_pin, // shift clock, idle high
   output logic     serial_data_pin  // serial data
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle link at time zero
   initial begin
      select_n_pin = 1'b1;
      shift_clock_pin = 1'b1;
      serial_data_pin = 1'b0;
   end

   // lsb first, rise mid-bit, no load strobe
   task automatic shift_bits(input int n, input logic [7:0] b);
      for (int i = 0; i < n; i++) begin
         shift_clock_pin <= 1'b0;
         serial_data_pin <= b[i];
         repeat (4) @(posedge sys_clk);
         shift_clock_pin <= 1'b1;
         repeat (4) @(posedge sys_clk);
      end
   endtask : shift_bits

   // one selected transfer of nbits, gap cycles after each byte
   task automatic frame(input int nbits, input logic [39:0] data, input int gap);
      @(posedge sys_clk);
      select_n_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < nbits; i += 8) begin
         shift_bits((nbits - i > 8) ? 8 : nbits - i, data[i +: 8]);
         repeat (gap) @(posedge sys_clk);
      end
      select_n_pin <= 1'b1;
      // released data line flips away from its last value
      serial_data_pin <= ~serial_data_pin;
      repeat (20) @(posedge sys_clk);
   endtask : frame
endmodule : vfd_host_model

// file: tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import vfd_pkg::*;

   typedef struct packed {
      logic [2:0]  kind;
      logic [15:0] exp;
   } vfd_note_s;

   logic        sys_clk;
   logic        rst_n;
   logic        select_n_pin;
   logic        shift_clock_pin;
   logic        serial_data_pin;
   logic [15:0] grid_outputs;
   logic [15:0] anode_segment_outputs;
   logic [1:0]  symbol_outputs;
   logic [3:0]  duty_bits;
   logic [3:0]  digit_count_bits;
   logic [15:0] pd0;
   logic [15:0] pd1;
   vfd_note_s   note_q[$];
   event        probe;
   int          error_cnt = 0;
   int          check_count = 0;
   int          seed = 32'h0bf8;

   vfd_host_model host (.sys_clk(sys_clk), .select_n_pin(select_n_pin),
      .shift_clock_pin(shift_clock_pin), .serial_data_pin(serial_data_pin));

   vfd_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .select_n_pin(select_n_pin),
      .shift_clock_pin(shift_clock_pin), .serial_data_pin(serial_data_pin),
      .grid_outputs(grid_outputs), .anode_segment_outputs(anode_segment_outputs),
      .symbol_outputs(symbol_outputs), .duty_bits(duty_bits),
      .digit_count_bits(digit_count_bits));

   // free-running clock
   always #12.5 sys_clk = ~sys_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // queue an expectation and wake the watcher
   task automatic note(input logic [2:0] kind, input logic [15:0] exp);
      #2;
      note_q.push_back(vfd_note_s'({kind, exp}));
      -> probe;
      #1;
   endtask : note

   // wait until digit d is lit, bounded
   task automatic wait_digit(input int d);
      int k;
      k = 0;
      while (grid_outputs !== (16'h1 << d) && k < 4000) begin
         @(posedge sys_clk);
         #1;
         k++;
      end
      check(grid_outputs, 16'h1 << d);
      repeat (3) @(posedge sys_clk);
   endtask : wait_digit

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run

   // compare the output named by the oldest note's kind against it
   always @(probe) begin : watch
      vfd_note_s n;
      n = note_q.pop_front();
      case (n.kind)
         3'h0: check({12'h0, duty_bits}, n.exp);
         3'h1: check({12'h0, digit_count_bits}, n.exp);
         3'h2: check(anode_segment_outputs, n.exp);
         3'h3: check({14'h0, symbol_outputs}, n.exp);
         default: check(grid_outputs, n.exp);
      endcase
   end

   // watchdog on a hung run
   initial begin
      #2000000;
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, 16'h0, 16'h1);
      complete_run();
   end

   // main sequence
   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      note(3'h0, 16'h0);
      note(3'h1, 16'h0);
      note(3'h4, 16'h0);
      note(3'h2, 16'h0);
      $display("test reset done");
      // every duty code, then a dropped partial byte
      for (int v = 0; v < 16; v++) begin
         host.frame(8, {32'h0, OP_DUTY, 4'(v)}, 0);
         note(3'h0, 16'(v));
      end
      host.frame(4, 40'h5a, 0);
      host.frame(8, {32'h0, OP_DUTY, 4'h7}, 0);
      note(3'h0, 16'h7);
      // unknown opcode opens the frame, the duty byte after it is ignored
      host.frame(16, {24'h0, OP_DUTY, 4'h9, 8'h8f}, 0);
      note(3'h0, 16'h7);
      $display("test duty done");
      host.frame(8, {32'h0, OP_DUTY, 4'hf}, 0);
      host.frame(8, {32'h0, OP_DIGITS, 4'h5}, 0);
      note(3'h1, 16'h5);
      // two pattern entries, three codes, two symbols
      pd0 = 16'($random(seed));
      pd1 = 16'($random(seed));
      host.frame(40, {pd1, pd0, OP_PAT, 4'h5}, BYTE_GAP_CYC);
      host.frame(32, {8'h41, 8'h06, 8'h05, OP_CHAR, 4'h2}, 40);
      host.frame(24, {16'h01fe, OP_SYM, 4'h2}, 40);
      wait_digit(2);
      note(3'h2, pd0);
      note(3'h3, 16'h2);
      wait_digit(3);
      note(3'h2, pd1);
      note(3'h3, 16'h1);
      wait_digit(4);
      note(3'h2, {8'h41 ^ 8'h5a, ~8'h41});
      note(3'h3, 16'h0);
      $display("test ram writes done");
      // all four lights codes
      for (int m = 0; m < 4; m++) begin
         host.frame(8, {32'h0, OP_LIGHTS, 2'h0, 2'(m)}, 0);
         wait_digit(2);
         note(3'h2, m[1] ? 16'hffff : (m[0] ? 16'h0 : pd0));
         note(3'h3, m[1] ? 16'h3 : (m[0] ? 16'h0 : 16'h2));
      end
      $display("test lights done");
      // second reset in mid-run
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      note(3'h0, 16'h0);
      note(3'h1, 16'h0);
      note(3'h4, 16'h0);
      note(3'h2, 16'h0);
      $display("test second reset done");
      complete_run();
   end
endmodule : tb
